//--- design/poroc_ctrl.sv
// AXI4-Lite register bank for phase offset steps, reference overrides and quick config
`timescale 1ns/1ps
`include "poroc_map.svh"
module poroc_ctrl
    import poroc_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [15:0] phase_step_size,
    output logic [15:0] phase_offset,
    output logic [3:0] validation_force,
    input wire logic [3:0] monitor_fault_raw,
    output logic [3:0] reference_fault,
    output logic [3:0] monitor_bypass,
    input wire logic pin_program_select,
    output logic qc_active,
    output logic qc_load,
    output logic [3:0] qc_input_index,
    output logic [3:0] qc_output_index
);

    // ------------------------------------------------------------------
    // State and decode helpers
    // ------------------------------------------------------------------
    poroc_state_t s;
    poroc_state_t next_s;
    logic wr_fire;
    logic [11:0] wr_idx;
    logic [7:0] wr_byte;
    logic ar_fire;
    logic [11:0] ar_idx;
    logic qc_on;

    // Word index from a byte address; upper address bits beyond the map are ignored
    function automatic logic [11:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[13:2];
    endfunction

    // True for every index the bank answers
    function automatic logic is_mapped(input logic [11:0] i);
        if (i == `POROC_IDX_PSTEP) begin
            return 1'b1;
        end else if (i == `POROC_IDX_FORCE || i == `POROC_IDX_OVRD) begin
            return 1'b1;
        end else if (i == `POROC_IDX_BYP || i == `POROC_IDX_POFS) begin
            return 1'b1;
        end else if (i == `POROC_IDX_QCEN || i == `POROC_IDX_QCSEL) begin
            return 1'b1;
        end else if (i == `POROC_IDX_QCSTAT) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction

    // ------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------
    // One write in flight: hold off new beats until the response is taken
    assign awready = !s.aw_full && !s.bvalid;
    assign wready = !s.w_full && !s.bvalid;
    assign arready = !s.rvalid;
    assign ar_fire = arvalid && arready;
    assign ar_idx = word_idx(araddr);
    assign wr_fire = s.aw_full && s.w_full && !s.bvalid;
    assign wr_idx = s.aw_idx;
    assign wr_byte = s.w_lane0 ? s.w_data : 8'h00;
    assign qc_on = s.cap_done && s.qc_enable && !s.pin_latched;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.force_expire = 4'h0;
        next_s.qc_load = 1'b0;
        // Address and data are taken in either order
        if (awvalid && awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_idx = word_idx(awaddr);
        end
        if (wvalid && wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = wdata[7:0];
            next_s.w_lane0 = wstrb[0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // Register writes; only byte lane 0 carries data
        if (wr_fire) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = is_mapped(wr_idx) ? `POROC_RESP_OKAY : `POROC_RESP_SLVERR;
            if (wr_idx == `POROC_IDX_PSTEP) begin
                // Reset wins; opposite steps in one write cancel
                if (wr_byte[`POROC_BIT_RST]) begin
                    next_s.phase_offset = `POROC_PHASE_RESET;
                end else if (wr_byte[`POROC_BIT_DEC] && !wr_byte[`POROC_BIT_INC]) begin
                    next_s.phase_offset = s.phase_offset - phase_step_size;
                end else if (wr_byte[`POROC_BIT_INC] && !wr_byte[`POROC_BIT_DEC]) begin
                    next_s.phase_offset = s.phase_offset + phase_step_size;
                end
            end else if (wr_idx == `POROC_IDX_FORCE) begin
                next_s.force_expire = wr_byte[3:0];
            end else if (wr_idx == `POROC_IDX_OVRD) begin
                next_s.fault_override = wr_byte[3:0];
            end else if (wr_idx == `POROC_IDX_BYP) begin
                next_s.monitor_bypass = wr_byte[3:0];
            end else if (wr_idx == `POROC_IDX_QCEN) begin
                next_s.qc_enable = wr_byte[0];
                next_s.qc_load = wr_byte[0] && s.cap_done && !s.pin_latched;
            end else if (wr_idx == `POROC_IDX_QCSEL) begin
                next_s.qc_select = wr_byte;
                next_s.qc_load = qc_on;
            end
        end
        // Reads answer one cycle after the address is taken
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = 32'h0000_0000;
            next_s.rresp = is_mapped(ar_idx) ? `POROC_RESP_OKAY : `POROC_RESP_SLVERR;
            // Strobe registers always read back zero since they clear themselves
            if (ar_idx == `POROC_IDX_OVRD) begin
                next_s.rdata[3:0] = s.fault_override;
            end else if (ar_idx == `POROC_IDX_BYP) begin
                next_s.rdata[3:0] = s.monitor_bypass;
            end else if (ar_idx == `POROC_IDX_POFS) begin
                next_s.rdata[15:0] = s.phase_offset;
            end else if (ar_idx == `POROC_IDX_QCEN) begin
                next_s.rdata[0] = s.qc_enable;
            end else if (ar_idx == `POROC_IDX_QCSEL) begin
                next_s.rdata[7:0] = s.qc_select;
            end else if (ar_idx == `POROC_IDX_QCSTAT) begin
                next_s.rdata[2:0] = {s.cap_done, s.pin_latched, qc_on};
            end
        end
        // Pin passes two flops, then is caught once after reset release
        next_s.pin_s1 = pin_program_select;
        next_s.pin_s2 = s.pin_s1;
        if (!s.cap_done) begin
            if (s.cap_cnt == `POROC_SYNC_CYCLES) begin
                next_s.cap_done = 1'b1;
                next_s.pin_latched = s.pin_s2;
                next_s.qc_load = s.qc_enable && !s.pin_s2;
            end else begin
                next_s.cap_cnt = s.cap_cnt + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.phase_offset <= `POROC_PHASE_RESET;
            s.fault_override <= `POROC_REF_RESET;
            s.monitor_bypass <= `POROC_REF_RESET;
            s.qc_select <= `POROC_QC_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign phase_offset = s.phase_offset;
    assign validation_force = s.force_expire;
    // Masking is gate-level so an override takes hold without a cycle of delay
    assign reference_fault = monitor_fault_raw & ~s.fault_override;
    assign monitor_bypass = s.monitor_bypass;
    assign qc_active = qc_on;
    assign qc_load = s.qc_load;
    // ROM address halves: 16 inputs by 16 outputs give the 256 translations
    assign qc_input_index = qc_on ? s.qc_select[3:0] : 4'h0;
    assign qc_output_index = qc_on ? s.qc_select[7:4] : 4'h0;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_write_step(int b);
        wr_fire && wr_idx == `POROC_IDX_PSTEP && wr_byte == (8'h01 << b);
    endsequence

    sequence seq_both_beats;
        awvalid && awready && wvalid && wready;
    endsequence

    a_phase_zero: assert property (
        wr_fire && wr_idx == `POROC_IDX_PSTEP && wr_byte[`POROC_BIT_RST]
        |=> phase_offset == 16'h0000)
        else $error("phase offset not zeroed");
    a_phase_down: assert property (
        seq_write_step(`POROC_BIT_DEC)
        |=> phase_offset == $past(phase_offset) - $past(phase_step_size))
        else $error("decrement step wrong");
    a_phase_up: assert property (
        seq_write_step(`POROC_BIT_INC)
        |=> phase_offset == $past(phase_offset) + $past(phase_step_size))
        else $error("increment step wrong");
    a_force_pulse: assert property (
        wr_fire && wr_idx == `POROC_IDX_FORCE
        |=> validation_force == $past(wr_byte[3:0]) ##1 validation_force == 4'h0)
        else $error("force pulse not one cycle");
    // Every overridden reference must show no fault, whatever the monitor says
    a_fault_mask: assert property (
        s.fault_override != 4'h0 |-> (reference_fault & s.fault_override) == 4'h0)
        else $error("override failed to mask fault");
    a_bypass_hold: assert property (
        !(wr_fire && wr_idx == `POROC_IDX_BYP) |=> $stable(monitor_bypass))
        else $error("bypass changed without a write");
    a_qc_gate: assert property (
        qc_active |-> s.qc_enable && !s.pin_latched && s.cap_done)
        else $error("quick config active without enable");
    a_qc_pin_ignore: assert property (
        s.pin_latched |-> !qc_active && !qc_load)
        else $error("quick config acted with pin high");
    a_reserved_zero: assert property (
        rvalid && $rose(rvalid) && $past(ar_idx) == `POROC_IDX_OVRD
        |-> rdata[31:4] == 28'h0)
        else $error("reserved bits read nonzero");
    // Beats taken at one edge, write runs at the next, response stands after that
    a_write_answer: assert property (
        seq_both_beats |-> ##2 bvalid)
        else $error("write response missing");
    a_qc_reload: assert property (
        wr_fire && wr_idx == `POROC_IDX_QCSEL && qc_active |=> qc_load)
        else $error("no rom load on new selection");
    a_qc_index: assert property (
        wr_fire && wr_idx == `POROC_IDX_QCSEL
        |=> !qc_active || {qc_output_index, qc_input_index} == $past(wr_byte))
        else $error("rom indices differ from selection");
    a_pin_hold: assert property (
        s.cap_done |=> $stable(s.pin_latched))
        else $error("pin program choice changed after capture");
    a_strobe_zero: assert property (
        $rose(rvalid) && ($past(ar_idx) == `POROC_IDX_PSTEP || $past(ar_idx) == `POROC_IDX_FORCE)
        |-> rdata == 32'h0000_0000)
        else $error("strobe register read nonzero");
endmodule

//--- inc/poroc_map.svh
// Register offsets, field positions, reset values and counts for the phase/ref/quick-config bank
// What this block does
// - Writing one to phase-reset strobe zeroes offset; strobe clears itself.
// - Writing one to decrement strobe subtracts step size once; self-clearing.
// - Writing one to increment strobe adds step size once; self-clearing.
// - Force bits 0-3 expire validation timer of references A-D at once; self-clearing.
// - Override bits 0-3 mask fault of references A-D while set; reset zero.
// - Bypass bits 0-3 remove monitor of references A-D while set; reset zero.
// - Quick config acts only when enabled and select pin low at reset.
// - Active quick config selects one of 256 ROM frequency translations.
// - Select pin high at reset makes quick config registers ignored.
// - Output field [7:4] picks one of 16 outputs, loading output settings.
// - Input field [3:0] picks one of 16 inputs, loading reference profiles.
`ifndef POROC_MAP_SVH
`define POROC_MAP_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define POROC_IDX_PSTEP 12'hA0A
`define POROC_IDX_FORCE 12'hA0B
`define POROC_IDX_OVRD 12'hA0C
`define POROC_IDX_BYP 12'hA0D
`define POROC_IDX_POFS 12'hA10
`define POROC_IDX_QCEN 12'hC00
`define POROC_IDX_QCSEL 12'hC01
`define POROC_IDX_QCSTAT 12'hC0F
// ----------------------------------------------------------------------
// Fields, resets, counts
// ----------------------------------------------------------------------
`define POROC_BIT_INC 0
`define POROC_BIT_DEC 1
`define POROC_BIT_RST 2
`define POROC_REF_RESET 4'h0
`define POROC_QC_RESET 8'h00
`define POROC_PHASE_RESET 16'h0000
`define POROC_SYNC_CYCLES 2'h2
`define POROC_RESP_OKAY 2'h0
`define POROC_RESP_SLVERR 2'h2
`endif

//--- inc/poroc_pkg.sv
// Types shared by the phase/ref/quick-config register bank
package poroc_pkg;
    // State of the whole bank, registered as one word
    typedef struct packed {
        logic aw_full;
        logic [11:0] aw_idx;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] phase_offset;
        logic [3:0] force_expire;
        logic [3:0] fault_override;
        logic [3:0] monitor_bypass;
        logic qc_enable;
        logic [7:0] qc_select;
        logic pin_s1;
        logic pin_s2;
        logic pin_latched;
        logic [1:0] cap_cnt;
        logic cap_done;
        logic qc_load;
    } poroc_state_t;
endpackage

//--- bench/test_poroc_ctrl.sv
// Self-checking bench for the phase/ref/quick-config register bank
`timescale 1ns/1ps
`include "poroc_map.svh"
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t %s got %h exp %h", $time, m, a, e); end end
module test_poroc_ctrl;
    // ----------------------------------------------------------------------
    // Clock, reset and stimulus signals
    // ----------------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic [13:0] awaddr = 14'h0000;
    logic [13:0] araddr = 14'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic [15:0] phase_step_size = 16'h0010;
    logic [3:0] monitor_fault_raw = 4'h0;
    logic pin_program_select = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, qc_active, qc_load;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] phase_offset;
    logic [3:0] validation_force, reference_fault, monitor_bypass;
    logic [3:0] qc_input_index, qc_output_index;
    logic [3:0] f_seen = 4'h0;
    int f_cyc = 0;
    int q_cnt = 0;
    int cyc = 0;
    int error_cnt = 0;
    int checked = 0;

    poroc_ctrl #(.ADDR_W(14)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .phase_step_size(phase_step_size), .phase_offset(phase_offset),
        .validation_force(validation_force), .monitor_fault_raw(monitor_fault_raw),
        .reference_fault(reference_fault), .monitor_bypass(monitor_bypass),
        .pin_program_select(pin_program_select), .qc_active(qc_active),
        .qc_load(qc_load), .qc_input_index(qc_input_index),
        .qc_output_index(qc_output_index)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // Pulse watchers: a one-cycle pulse is easy to miss from the task flow
    always @(posedge aclk) begin
        cyc++;
        if (validation_force != 4'h0) f_cyc++;
        if (qc_load === 1'b1) q_cnt++;
        // Outputs are unknown until the first reset edge; keep them out of the sum
        if (aresetn) f_seen = f_seen | validation_force;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------------
    // Write one word; waits for the answer, only the bench timeout ends a hang
    // Ready stays high between calls so no signal is driven twice in one step
    task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic [1:0] r;
        r = 2'bxx;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        `CHK(r, er, "write response")
    endtask

    task automatic axi_rd(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
        logic [1:0] r;
        logic [31:0] d;
        r = 2'bxx;
        d = 32'hxxxx_xxxx;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                r = rresp;
                d = rdata;
                break;
            end
        end
        `CHK(r, er, "read response")
        `CHK(d, ed, "read data")
    endtask

    // Reset for ten cycles, then let the select pin be captured
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
    endtask

    task automatic tick();
        @(posedge aclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------------
    initial begin
        do_reset();
        axi_rd(`POROC_IDX_OVRD, 32'h0, `POROC_RESP_OKAY);
        axi_rd(`POROC_IDX_BYP, 32'h0, `POROC_RESP_OKAY);
        `CHK(qc_active, 1'b0, "qc idle after reset")
        $display("test reset values done");
        // Step up once, down twice across zero, both at once, then clear
        axi_wr(`POROC_IDX_PSTEP, 8'h01, `POROC_RESP_OKAY);
        tick();
        `CHK(phase_offset, 16'h0010, "increment")
        axi_wr(`POROC_IDX_PSTEP, 8'h02, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_PSTEP, 8'h02, `POROC_RESP_OKAY);
        tick();
        `CHK(phase_offset, 16'hFFF0, "decrement twice")
        axi_wr(`POROC_IDX_PSTEP, 8'h03, `POROC_RESP_OKAY);
        tick();
        `CHK(phase_offset, 16'hFFF0, "inc and dec together")
        axi_rd(`POROC_IDX_POFS, 32'h0000_FFF0, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_PSTEP, 8'h07, `POROC_RESP_OKAY);
        tick();
        `CHK(phase_offset, 16'h0000, "offset cleared")
        axi_rd(`POROC_IDX_PSTEP, 32'h0, `POROC_RESP_OKAY);
        $display("test phase steps done");
        // Force strobes: one pulse of the written references only
        axi_wr(`POROC_IDX_FORCE, 8'hF5, `POROC_RESP_OKAY);
        repeat (3) tick();
        `CHK(f_seen, 4'h5, "force pulse refs")
        `CHK(f_cyc, 1, "force pulse width")
        axi_rd(`POROC_IDX_FORCE, 32'h0, `POROC_RESP_OKAY);
        // Override masks faults, bypass is a plain level
        monitor_fault_raw <= 4'hF;
        axi_wr(`POROC_IDX_OVRD, 8'hF3, `POROC_RESP_OKAY);
        tick();
        `CHK(reference_fault, 4'hC, "fault masked")
        axi_rd(`POROC_IDX_OVRD, 32'h3, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_BYP, 8'hA9, `POROC_RESP_OKAY);
        tick();
        `CHK(monitor_bypass, 4'h9, "bypass level")
        axi_rd(`POROC_IDX_BYP, 32'h9, `POROC_RESP_OKAY);
        $display("test reference controls done");
        // Quick config with the pin low: enable selects the translation
        axi_wr(`POROC_IDX_QCSEL, 8'hA5, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_QCEN, 8'hFF, `POROC_RESP_OKAY);
        tick();
        `CHK(qc_active, 1'b1, "qc active")
        `CHK({qc_output_index, qc_input_index}, 8'hA5, "qc indices")
        `CHK(q_cnt, 1, "rom load request")
        axi_rd(`POROC_IDX_QCSTAT, 32'h5, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_QCSEL, 8'h5A, `POROC_RESP_OKAY);
        tick();
        `CHK({qc_output_index, qc_input_index}, 8'h5A, "qc new indices")
        `CHK(q_cnt, 2, "rom reload request")
        axi_rd(`POROC_IDX_QCEN, 32'h1, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_QCEN, 8'h00, `POROC_RESP_OKAY);
        tick();
        `CHK(qc_active, 1'b0, "qc disabled")
        `CHK({qc_output_index, qc_input_index}, 8'h00, "indices idle")
        // Pin high at reset: register contents are ignored
        pin_program_select <= 1'b1;
        do_reset();
        axi_wr(`POROC_IDX_QCSEL, 8'h3C, `POROC_RESP_OKAY);
        axi_wr(`POROC_IDX_QCEN, 8'h01, `POROC_RESP_OKAY);
        tick();
        `CHK(qc_active, 1'b0, "pin program wins")
        `CHK({qc_output_index, qc_input_index}, 8'h00, "indices ignored")
        `CHK(q_cnt, 2, "no rom load with pin high")
        axi_rd(`POROC_IDX_QCSTAT, 32'h6, `POROC_RESP_OKAY);
        axi_rd(`POROC_IDX_QCSEL, 32'h3C, `POROC_RESP_OKAY);
        $display("test quick config done");
        // Unmapped places answer with an error and no data
        axi_rd(12'h123, 32'h0, `POROC_RESP_SLVERR);
        axi_wr(12'h124, 8'h55, `POROC_RESP_SLVERR);
        $display("test unmapped done");
        wrap_up();
    end
endmodule
